/* dv/xcv_ctrl_tb_top.sv */
`include "xcv_params.svh"

module xcv_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P_INIT = 50;
  logic        clk, arst_n, off, go, rate, fdet, ldet, wr, rd, tx_off, rsel, sid_clk;
  logic        rate_q[$];
  time         t0;
  int          m_irq;
  logic [15:0] hold;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, seed, r;
  logic        laser, fault, los, bw, busy, irq;
  int          fail_count, total_checks, exp_stat;

  xcv_host_model host (.i_core_clk(clk), .i_arst_n(arst_n), .i_off(off), .i_go(go),
    .i_hold(hold), .i_rate(rate), .o_tx_off(tx_off), .o_rate_sel(rsel),
    .o_sid_clk(sid_clk));

  xcv_ctrl #(.P_INIT_CYC(P_INIT)) dut (.i_core_clk(clk), .i_arst_n(arst_n),
    .i_tx_off(tx_off), .i_rate_sel(rsel), .i_fault_det(fdet), .i_los_det(ldet),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rd_data(rdata),
    .o_laser_en(laser), .o_tx_fault(fault), .o_rx_los(los), .o_rx_bw_sel(bw),
    .o_init_busy(busy), .o_irq(irq));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic get_out(input int sel);
    case (sel)
      0: return laser;
      1: return fault;
      2: return los;
      3: return bw;
      4: return busy;
      default: return irq;
    endcase
  endfunction

  // Bounded wait for an output level, then compare it
  task automatic wait_out(input int sel, input logic v, input int lim);
    for (int n = 0; n < lim; n++) begin
      @(posedge clk);
      #1;
      if (get_out(sel) === v) break;
    end
    check({31'h0, get_out(sel)}, {31'h0, v});
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  task automatic pulse(input logic [15:0] h);
    @(posedge clk);
    go   <= 1'b1;
    hold <= h;
    @(posedge clk);
    go   <= 1'b0;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog far beyond a clean run, which takes a few thousand cycles
  initial begin
    #(25 * 50000);
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    {arst_n, off, go, rate, fdet, ldet, wr, rd} = 8'h00;
    hold = 16'h0000;
    addr = 8'h00;
    wdata = 32'h0;
    seed = 32'h0000189E;
    fail_count = 0;
    total_checks = 0;
    m_irq = 0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    wait_out(4, 1'b0, P_INIT + 10);
    wait_out(0, 1'b1, 40);
    exp_stat = 1 << `XCV_ST_LASER;
    m_irq = 1 << `XCV_EV_INIT_DONE;
    bus_rd(`XCV_REG_STATUS, exp_stat);
    bus_rd(`XCV_REG_CTRL, 32'h0);
    bus_rd(`XCV_REG_IRQ_MASK, 32'h0);
    bus_rd(8'h10, 32'h0);
    bus_rd(`XCV_REG_IRQ_STAT, m_irq);
    bus_wr(`XCV_REG_IRQ_STAT, m_irq);
    m_irq = 0;
    bus_rd(`XCV_REG_IRQ_STAT, m_irq);
    $display("test reset_init done");

    for (int i = 0; i < 3; i++) begin
      @(posedge clk) off <= 1'b1;
      wait_out(0, 1'b0, 400);
      @(posedge clk) off <= 1'b0;
      wait_out(0, 1'b1, 40000);
    end
    // Software off must gate the laser just as the pin does
    bus_wr(`XCV_REG_CTRL, 1 << `XCV_CTRL_SOFT_OFF);
    wait_out(0, 1'b0, 10);
    bus_rd(`XCV_REG_CTRL, 1 << `XCV_CTRL_SOFT_OFF);
    bus_rd(`XCV_REG_STATUS, 32'h0);
    bus_wr(`XCV_REG_CTRL, 32'h0);
    wait_out(0, 1'b1, 10);
    $display("test tx_off done");

    for (int i = 0; i < 6; i++) begin
      r = xs();
      rate_q.push_back(r[0]);
      @(posedge clk) rate <= r[0];
      wait_out(3, rate_q.pop_front(), 400);
    end
    @(posedge clk) rate <= 1'b0;
    wait_out(3, 1'b0, 400);
    $display("test rate_select done");

    bus_wr(`XCV_REG_IRQ_MASK, 1 << `XCV_EV_FAULT);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) ldet <= 1'b1;
      wait_out(2, 1'b1, 4000);
      check({31'h0, irq}, 32'h0);
      @(posedge clk) ldet <= 1'b0;
      wait_out(2, 1'b0, 4000);
    end
    m_irq = (1 << `XCV_EV_LOS_ON) | (1 << `XCV_EV_LOS_OFF);
    bus_rd(`XCV_REG_IRQ_STAT, m_irq);
    $display("test los done");

    @(posedge clk) fdet <= 1'b1;
    wait_out(1, 1'b1, 4000);
    wait_out(0, 1'b0, 400);
    wait_out(5, 1'b1, 10);
    @(posedge clk) fdet <= 1'b0;
    // One cycle short of the least hold time must be refused
    pulse(16'h018F);
    repeat (600) @(posedge clk);
    #1;
    check({31'h0, fault}, 32'h1);
    pulse(16'h0190);
    wait_out(1, 1'b0, 500);
    check({31'h0, busy}, 32'h1);
    wait_out(4, 1'b0, P_INIT + 10);
    wait_out(0, 1'b1, 40);
    m_irq = m_irq | (1 << `XCV_EV_FAULT) | (1 << `XCV_EV_INIT_DONE);
    bus_rd(`XCV_REG_IRQ_STAT, m_irq);
    bus_wr(`XCV_REG_IRQ_STAT, 32'hF);
    m_irq = 0;
    wait_out(5, 1'b0, 10);
    bus_rd(`XCV_REG_IRQ_STAT, m_irq);
    bus_rd(`XCV_REG_STATUS, exp_stat);
    $display("test fault_clear done");

    @(posedge sid_clk);
    t0 = $time;
    @(posedge sid_clk);
    check({31'h0, ($time - t0) >= (1000000 / `XCV_SID_MAX_KHZ)}, 32'h1);
    $display("test sid_clock done");
    test_done();
  end
endmodule // xcv_ctrl_tb_top

/* dv/xcv_host_model.sv */
`include "xcv_params.svh"

// ----------------------------------------------------------------------
// Host board control model: drives the transmit-off and rate pins
// ----------------------------------------------------------------------
module xcv_host_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_off,
  input  wire logic        i_go,
  input  wire logic [15:0] i_hold,
  input  wire logic        i_rate,
  output logic             o_tx_off,
  output logic             o_rate_sel,
  output logic             o_sid_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt;
  logic [15:0] sid_div;

  // Management link clock runs free; half period rounded up keeps it at or below the limit
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sid_div   <= 16'h0000;
      o_sid_clk <= 1'b0;
    end else if (sid_div == 16'(`XCV_SID_HALF_CYC - 1)) begin
      sid_div   <= 16'h0000;
      o_sid_clk <= ~o_sid_clk;
    end else begin
      sid_div <= sid_div + 16'h0001;
    end
  end

  // Pulse length is set by the bench, so a too-short clear can be commanded
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt <= 16'h0000;
    end else if (i_go) begin
      cnt <= i_hold;
    end else if (cnt != 16'h0000) begin
      cnt <= cnt - 16'h0001;
    end
  end

  assign o_tx_off   = i_off | (cnt != 16'h0000);
  assign o_rate_sel = i_rate;
endmodule // xcv_host_model

/* hdl/xcv_ctrl.sv */
// Added by the designer: the register offsets and the plain strobed port.
`include "xcv_params.svh"

module xcv_ctrl import xcv_pkg::*; #(
  parameter int P_INIT_CYC = `XCV_T_INIT_CYC
) (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_arst_n,
  input  wire logic                   i_tx_off,
  input  wire logic                   i_rate_sel,
  input  wire logic                   i_fault_det,
  input  wire logic                   i_los_det,
  input  wire logic [`XCV_ADDR_W-1:0] i_addr,
  input  wire logic [`XCV_DATA_W-1:0] i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic [`XCV_DATA_W-1:0]      o_rd_data,
  output logic                        o_laser_en,
  output logic                        o_tx_fault,
  output logic                        o_rx_los,
  output logic                        o_rx_bw_sel,
  output logic                        o_init_busy,
  output logic                        o_irq
);
  // ----------------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------------
  xcv_pins_t pins_raw;
  xcv_pins_t pins_m;
  xcv_pins_t pins_q;
  xcv_bus_t  bus;

  assign pins_raw = '{tx_off: i_tx_off, rate_sel: i_rate_sel,
                      fault_det: i_fault_det, los_det: i_los_det};
  assign bus      = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pins_m <= '0;
      pins_q <= '0;
    end else begin
      pins_m <= pins_raw;
      pins_q <= pins_m;
    end
  end

  logic tx_off_q;
  logic tx_off_d;
  logic fault_q;
  logic los_q;
  logic rate_q;

  assign tx_off_q = pins_q.tx_off;
  assign fault_q  = pins_q.fault_det;
  assign los_q    = pins_q.los_det;
  assign rate_q   = pins_q.rate_sel;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_off_d <= 1'b0;
    end else begin
      tx_off_d <= tx_off_q;
    end
  end

  // ----------------------------------------------------------------------
  // Interval timers
  // ----------------------------------------------------------------------
  xcv_state_t state;
  xcv_state_t next_state;
  logic       hold_hit;
  logic       hold_ok;
  logic       init_hit;
  logic       los_hit;
  logic       soft_off;

  // Limit is one short: the set lands an edge later, so exactly 10 us qualifies
  xcv_timer #(.WIDTH(16)) u_hold (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_run      (tx_off_q && (state == XCV_FAULT)),
    .i_limit    (16'(`XCV_T_RESET_CYC - 1)),
    .o_hit      (hold_hit)
  );

  xcv_timer #(.WIDTH(24)) u_init (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_run      (state == XCV_INIT),
    .i_limit    (24'(P_INIT_CYC)),
    .o_hit      (init_hit)
  );

  // Loss detector glitch filter; far below the loss response bound
  xcv_timer #(.WIDTH(16)) u_los (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_run      (los_q != o_rx_los),
    .i_limit    (16'(`XCV_LOS_FILT_CYC)),
    .o_hit      (los_hit)
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      XCV_INIT: begin
        if (fault_q) begin
          next_state = XCV_FAULT;
        end else if (init_hit) begin
          next_state = XCV_RUN;
        end
      end
      XCV_RUN: begin
        if (fault_q) begin
          next_state = XCV_FAULT;
        end
      end
      XCV_FAULT: begin
        // Only a qualified pulse clears; its release restarts init
        if (hold_ok && !tx_off_q && !fault_q) begin
          next_state = XCV_INIT;
        end
      end
      default: begin
        next_state = XCV_INIT;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= XCV_INIT;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hold_ok <= 1'b0;
    end else if (state != XCV_FAULT) begin
      hold_ok <= 1'b0;
    end else if (hold_hit) begin
      hold_ok <= 1'b1;
    end else if (!tx_off_q) begin
      hold_ok <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------------
  // Laser drive is gated by the synced request directly, a few cycles only
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_laser_en <= 1'b0;
    end else begin
      o_laser_en <= (next_state == XCV_RUN) && !tx_off_q && !soft_off;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_tx_fault <= 1'b0;
    end else begin
      o_tx_fault <= (next_state == XCV_FAULT);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rx_los <= 1'b0;
    end else if (los_hit) begin
      o_rx_los <= los_q;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rx_bw_sel <= 1'b0;
    end else begin
      o_rx_bw_sel <= rate_q;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_init_busy <= 1'b1;
    end else begin
      o_init_busy <= (next_state == XCV_INIT);
    end
  end

  // ----------------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------------
  logic [`XCV_EV_W-1:0] events;
  logic [`XCV_EV_W-1:0] irq_stat;
  logic [`XCV_EV_W-1:0] irq_mask;
  logic [`XCV_EV_W-1:0] w1c;

  always_comb begin
    events                     = '0;
    events[`XCV_EV_FAULT]      = (state != XCV_FAULT) && (next_state == XCV_FAULT);
    events[`XCV_EV_LOS_ON]     = los_hit && los_q;
    events[`XCV_EV_LOS_OFF]    = los_hit && !los_q;
    events[`XCV_EV_INIT_DONE]  = (state == XCV_INIT) && (next_state == XCV_RUN);
  end

  assign w1c = (bus.wr && (bus.addr == `XCV_REG_IRQ_STAT)) ?
               bus.wdata[`XCV_EV_W-1:0] : '0;

  // A new event wins over a simultaneous clear
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~w1c) | events;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(((irq_stat & ~w1c) | events) & irq_mask);
    end
  end

  // ----------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      soft_off <= `XCV_CTRL_RST;
      irq_mask <= `XCV_MASK_RST;
    end else if (bus.wr) begin
      if (bus.addr == `XCV_REG_CTRL) begin
        soft_off <= bus.wdata[`XCV_CTRL_SOFT_OFF];
      end
      if (bus.addr == `XCV_REG_IRQ_MASK) begin
        irq_mask <= bus.wdata[`XCV_EV_W-1:0];
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_data <= '0;
    end else if (bus.rd) begin
      o_rd_data <= '0;
      case (bus.addr)
        `XCV_REG_CTRL: begin
          o_rd_data[`XCV_CTRL_SOFT_OFF] <= soft_off;
        end
        `XCV_REG_STATUS: begin
          o_rd_data[`XCV_ST_FAULT] <= o_tx_fault;
          o_rd_data[`XCV_ST_LOS]   <= o_rx_los;
          o_rd_data[`XCV_ST_LASER] <= o_laser_en;
          o_rd_data[`XCV_ST_INIT]  <= o_init_busy;
          o_rd_data[`XCV_ST_BW]    <= o_rx_bw_sel;
        end
        `XCV_REG_IRQ_STAT: begin
          o_rd_data[`XCV_EV_W-1:0] <= irq_stat;
        end
        `XCV_REG_IRQ_MASK: begin
          o_rd_data[`XCV_EV_W-1:0] <= irq_mask;
        end
        default: begin
          o_rd_data <= '0;
        end
      endcase
    end else begin
      o_rd_data <= '0;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_off_req;
    tx_off_q && !tx_off_d;
  endsequence

  sequence s_on_req;
    $fell(tx_off_q) && (state == XCV_RUN) && !fault_q && !soft_off;
  endsequence

  sequence s_short_release;
    (state == XCV_FAULT) && !hold_ok && $fell(tx_off_q);
  endsequence

  AST_TX_OFF_FAST: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    s_off_req |-> ##[0:1] !o_laser_en ##1 !o_laser_en)
    else $error("laser still on after transmit-off request");

  AST_TX_ON: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    s_on_req |=> o_laser_en)
    else $error("laser not restored after transmit-off release");

  AST_INIT_END: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (state == XCV_INIT) && init_hit && !fault_q |=> (state == XCV_RUN) ##1 o_laser_en
      || tx_off_q || soft_off || fault_q)
    else $error("init did not complete on timer expiry");

  AST_NO_LASER_INIT: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    o_init_busy |-> !o_laser_en)
    else $error("laser enabled during init");

  AST_FAULT_SET: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    fault_q |=> o_tx_fault && !o_laser_en)
    else $error("fault flag late or laser left on");

  AST_FAULT_HOLD: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    s_short_release |=> o_tx_fault [*2])
    else $error("short transmit-off pulse cleared the fault");

  AST_FAULT_CLEAR: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    $fell(o_tx_fault) |-> $past(tx_off_q, 2) && !$past(tx_off_q))
    else $error("fault cleared without a qualified release");

  AST_LOS_ON: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    los_q && !o_rx_los |-> ##[1:50] (o_rx_los || !los_q))
    else $error("loss flag not raised in time");

  AST_LOS_OFF: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    !los_q && o_rx_los |-> ##[1:50] (!o_rx_los || los_q))
    else $error("loss flag not dropped in time");

  AST_RATE: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    $changed(rate_q) |=> o_rx_bw_sel == $past(rate_q))
    else $error("bandwidth select did not follow the input");
endmodule // xcv_ctrl

/* hdl/xcv_timer.sv */
// Interval counter: counts while running, reports reaching the limit,
// restarts whenever run drops.
module xcv_timer #(
  parameter int WIDTH = 16
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_arst_n,
  input  wire logic             i_run,
  input  wire logic [WIDTH-1:0] i_limit,
  output logic                  o_hit
);
  logic [WIDTH-1:0] count;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count <= '0;
    end else if (!i_run) begin
      count <= '0;
    end else if (count < i_limit) begin
      count <= count + WIDTH'(1);
    end
  end

  assign o_hit = i_run && (count >= i_limit);
endmodule // xcv_timer

/* shared/xcv_params.svh */
`ifndef XCV_PARAMS_SVH
`define XCV_PARAMS_SVH
// Operation
// - Rising transmit-off drops optical output within 10 us.
// - Falling transmit-off restores modulated output within 1 ms.
// - Initialization finishes within 300 ms of power-on or fault clear; the init timer here runs the full 300 ms plus one cycle.
// - A laser fault raises the fault flag within 100 us.
// - Signal loss raises the loss flag within 100 us.
// - Signal return drops the loss flag within 100 us.
// - Bandwidth follows the rate select input within 10 us.

// ----------------------------------------------------------------------
// Clock and times
// ----------------------------------------------------------------------
`define XCV_CLK_NS        25
`define XCV_T_OFF_NS      10000
`define XCV_T_ON_NS       1000000
`define XCV_T_INIT_MS     300
`define XCV_T_FAULT_NS    100000
`define XCV_T_RESET_NS    10000
`define XCV_T_LOSS_NS     100000
`define XCV_T_RATESEL_NS  10000
`define XCV_LOS_FILT_NS   1000
// Longest times round down, least times round up
`define XCV_T_OFF_CYC     (`XCV_T_OFF_NS / `XCV_CLK_NS)
`define XCV_T_ON_CYC      (`XCV_T_ON_NS / `XCV_CLK_NS)
`define XCV_T_INIT_CYC    (`XCV_T_INIT_MS * 1000000 / `XCV_CLK_NS)
`define XCV_T_FAULT_CYC   (`XCV_T_FAULT_NS / `XCV_CLK_NS)
`define XCV_T_RESET_CYC   ((`XCV_T_RESET_NS + `XCV_CLK_NS - 1) / `XCV_CLK_NS)
`define XCV_T_LOSS_CYC    (`XCV_T_LOSS_NS / `XCV_CLK_NS)
`define XCV_LOS_FILT_CYC  ((`XCV_LOS_FILT_NS + `XCV_CLK_NS - 1) / `XCV_CLK_NS)
`define XCV_SID_MAX_KHZ   100
`define XCV_SID_HALF_CYC  ((1000000 / `XCV_SID_MAX_KHZ + 2 * `XCV_CLK_NS - 1) / (2 * `XCV_CLK_NS))

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define XCV_ADDR_W        8
`define XCV_DATA_W        32
`define XCV_REG_CTRL      8'h00
`define XCV_REG_STATUS    8'h04
`define XCV_REG_IRQ_STAT  8'h08
`define XCV_REG_IRQ_MASK  8'h0C
`define XCV_CTRL_SOFT_OFF 0
`define XCV_ST_FAULT      0
`define XCV_ST_LOS        1
`define XCV_ST_LASER      2
`define XCV_ST_INIT       3
`define XCV_ST_BW         4
`define XCV_EV_W          4
`define XCV_EV_FAULT      0
`define XCV_EV_LOS_ON     1
`define XCV_EV_LOS_OFF    2
`define XCV_EV_INIT_DONE  3
`define XCV_CTRL_RST      1'h0
`define XCV_MASK_RST      4'h0
`endif

/* shared/xcv_pkg.sv */
package xcv_pkg;
  typedef enum logic [1:0] {
    XCV_INIT  = 2'b00,
    XCV_RUN   = 2'b01,
    XCV_FAULT = 2'b10
  } xcv_state_t;

  // Pin-level inputs, sampled together through one synchroniser
  typedef struct packed {
    logic tx_off;
    logic rate_sel;
    logic fault_det;
    logic los_det;
  } xcv_pins_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } xcv_bus_t;
endpackage
